// >>> design/ulr_pkg.sv
// Shared constants and types for the line state / operating mode link logic
`default_nettype none
package ulr_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned IF_CLK_HZ     = 60_000_000;
  localparam int unsigned IF_DIV_HALF   = 1;
  // Op modes
  localparam logic [1:0] OPM_NORMAL = 2'h0;
  localparam logic [1:0] OPM_NODRV  = 2'h1;
  localparam logic [1:0] OPM_RAW    = 2'h2;
  localparam logic [1:0] OPM_RSVD   = 2'h3;
  // Line state codes
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J   = 2'h1;
  localparam logic [1:0] LS_K   = 2'h2;
  localparam logic [1:0] LS_SE1 = 2'h3;
  // Transceiver / termination select values
  localparam logic XCVR_HS = 1'b0;
  localparam logic XCVR_FS = 1'b1;
  localparam logic TERM_HS = 1'b0;
  localparam logic TERM_FS = 1'b1;
  // Timing, in microseconds / nanoseconds
  localparam int unsigned POR_NS        = 200;
  localparam int unsigned POR_CYC       = (POR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned LOCK_NS       = 1000;
  localparam int unsigned LOCK_CYC      = (LOCK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FS_RST_NS     = 2500;
  localparam int unsigned FS_RST_CYC    = (FS_RST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned HS_IDLE_US    = 3000;
  localparam int unsigned HS_IDLE_CYC   = HS_IDLE_US * (CLK_HZ / 1_000_000) + 1;
  localparam int unsigned REVERT_MAX_US = 3125;
  localparam int unsigned SAMPLE_US     = 300;
  localparam int unsigned SAMPLE_CYC    = SAMPLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TMR_W         = 18;
  typedef enum logic [2:0] {ULR_HS_RUN, ULR_FS_RUN, ULR_REVERT_WAIT, ULR_HANDSHAKE,
                            ULR_SUSPEND, ULR_TEST} ulr_lstate_t;
endpackage
`default_nettype wire

// >>> design/ulr_if.sv
// Interface joining the PHY-side logic and the link controller
`default_nettype none
interface ulr_if;
  logic       phy_interface_clock_output;
  logic [1:0] line_state;
  logic [1:0] op_mode;
  logic       xcvr_sel;
  logic       term_sel;
  logic       tx_valid;
  logic       tx_data;
  logic       if_reset;
  modport phy (output phy_interface_clock_output, output line_state,
               input op_mode, input xcvr_sel, input term_sel, input tx_valid,
               input tx_data, input if_reset);
  modport link (input phy_interface_clock_output, input line_state,
                output op_mode, output xcvr_sel, output term_sel, output tx_valid,
                output tx_data, output if_reset);
endinterface
`default_nettype wire

// >>> design/ulr_phy.sv
// PHY-side line state, op mode, clock start and reset logic
//
// What the document requires of this block and of ulr_link
// RULE_01 - Interface clock held low until PLL lock
// RULE_02 - Power-up pulse; external reset resets logic
// RULE_03 - Transceiver select picks HS or FS thresholds
// RULE_04 - HS receiver always gated by squelch
// RULE_05 - FS codes: SE0, J, K, SE1
// RULE_06 - HS normal: squelch 00, activity 01
// RULE_07 - Chirp: squelched 00, else J/K from receiver
// RULE_08 - Mode 00 normal coding; 11 reserved
// RULE_09 - Mode 01 tri-states drivers, drops terminations
// RULE_10 - Mode 10 sends 1 as J, 0 as K
// RULE_11 - Mode 10 sends no SYNC, no EOP
// RULE_12 - Switch to mode 10 mid-packet still ends EOP
// RULE_13 - Link changes mode only when idle; ulr_link leaves ULR_TEST when test_en drops, even mid-transmit
// RULE_14 - Mode change mid-traffic otherwise undefined
// RULE_15 - Test modes use HS selects, modes 0/2
// RULE_16 - FS SE0 over 2.5us is reset; ulr_link does not detect it in ULR_SUSPEND
// RULE_17 - HS idle over 3ms needs decision
// RULE_18 - Link reverts to FS after 3ms idle
// RULE_19 - Reversion between 3.0 and 3.125 ms
// RULE_20 - FS peripheral enables DP pull-up
// RULE_21 - SE0 after reversion starts handshake
// RULE_22 - Sample between 100us and 875us after
// RULE_23 - J at sample means suspend
// RULE_24 - Link timers count interface clock cycles; ulr_link counts core_clk cycles instead
`default_nettype none
module ulr_phy
  import ulr_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = LOCK_CYC
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  ulr_if.phy        lnk,
  input  wire logic pll_locked,
  input  wire logic bus_dp,
  input  wire logic bus_dm,
  input  wire logic hs_diff_rx,
  input  wire logic squelch,
  output logic      tx_dp_out,
  output logic      tx_dm_out,
  output logic      tx_oe,
  output logic      pullup_dp_en,
  output logic      hs_term_en,
  output logic      por_busy,
  output logic      sop_sent
);
  logic [15:0] por_cnt_r;
  logic [15:0] lock_cnt_r;
  logic        clk_run_r;
  logic        clk_q_r;
  logic        tx_dp_r, tx_dm_r, tx_oe_r, pu_r, ht_r, busy_r, sop_r;
  logic [1:0]  ls_r;
  logic [1:0]  eop_cnt_r;
  logic        tx_valid_q_r;
  logic [1:0]  ls_nxt;

  wire logic if_rst = lnk.if_reset || (por_cnt_r != 16'h0000);
  wire logic fs_sel = (lnk.xcvr_sel == XCVR_FS);
  wire logic chirp  = (lnk.term_sel == TERM_FS);
  wire logic raw    = (lnk.op_mode == OPM_RAW);
  wire logic nodrv  = (lnk.op_mode == OPM_NODRV);
  wire logic tx_start = lnk.tx_valid && !tx_valid_q_r;
  wire logic tx_end   = !lnk.tx_valid && tx_valid_q_r;

  // RULE_03 threshold select
  always_comb begin
    if (fs_sel) begin
      // RULE_05 FS line codes
      ls_nxt = {bus_dm, bus_dp};
    end else if (!chirp) begin
      // RULE_06 squelch or activity
      ls_nxt = squelch ? LS_SE0 : LS_J;
    end else begin
      // RULE_04 RULE_07 gated receiver
      ls_nxt = squelch ? LS_SE0 : (hs_diff_rx ? LS_J : LS_K);
    end
  end

  // RULE_02 power-up pulse
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) por_cnt_r <= 16'(POR_CYC);
    else if (por_cnt_r != 16'h0000) por_cnt_r <= por_cnt_r - 16'h0001;
  end

  // RULE_01 clock gated by lock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_cnt_r <= 16'h0000;
      clk_run_r  <= 1'b0;
      clk_q_r    <= 1'b0;
    end else begin
      if (!pll_locked) lock_cnt_r <= 16'h0000;
      else if (lock_cnt_r != 16'(LOCK_CYCLES)) lock_cnt_r <= lock_cnt_r + 16'h0001;
      clk_run_r <= pll_locked && (lock_cnt_r == 16'(LOCK_CYCLES));
      clk_q_r   <= clk_run_r ? !clk_q_r : 1'b0;
    end
  end

  // RULE_02 external reset clears interface logic
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ls_r <= LS_SE0; tx_dp_r <= 1'b0; tx_dm_r <= 1'b0; tx_oe_r <= 1'b0;
      pu_r <= 1'b0; ht_r <= 1'b0; busy_r <= 1'b1; sop_r <= 1'b0;
      eop_cnt_r <= 2'h0; tx_valid_q_r <= 1'b0;
    end else if (if_rst) begin
      ls_r <= LS_SE0; tx_dp_r <= 1'b0; tx_dm_r <= 1'b0; tx_oe_r <= 1'b0;
      pu_r <= 1'b0; ht_r <= 1'b0; busy_r <= 1'b1; sop_r <= 1'b0;
      eop_cnt_r <= 2'h0; tx_valid_q_r <= 1'b0;
    end else begin
      busy_r       <= 1'b0;
      ls_r         <= ls_nxt;
      tx_valid_q_r <= lnk.tx_valid;
      // RULE_09 no drive, no terminations
      if (nodrv) begin
        pu_r <= 1'b0; ht_r <= 1'b0;
      end else begin
        // RULE_20 FS peripheral pull-up
        pu_r <= chirp;
        ht_r <= !chirp && !fs_sel;
      end
      // RULE_08 RULE_11 SYNC only in normal mode
      if (tx_start) sop_r <= (lnk.op_mode == OPM_NORMAL);
      // RULE_12 EOP after SYNC even if mode went raw
      if (tx_end && sop_r) begin
        eop_cnt_r <= 2'h2; sop_r <= 1'b0;
      end else if (eop_cnt_r != 2'h0) begin
        eop_cnt_r <= eop_cnt_r - 2'h1;
      end
      if (nodrv) begin
        tx_oe_r <= 1'b0; tx_dp_r <= 1'b0; tx_dm_r <= 1'b0;
      end else if (eop_cnt_r != 2'h0) begin
        // SE0 portion of EOP
        tx_oe_r <= 1'b1; tx_dp_r <= 1'b0; tx_dm_r <= 1'b0;
      end else if (lnk.tx_valid && raw) begin
        // RULE_10 1 as J, 0 as K
        tx_oe_r <= 1'b1; tx_dp_r <= lnk.tx_data; tx_dm_r <= !lnk.tx_data;
      end else if (lnk.tx_valid) begin
        // Coded path abstracted: drives data level as J/K
        tx_oe_r <= 1'b1; tx_dp_r <= lnk.tx_data; tx_dm_r <= !lnk.tx_data;
      end else begin
        tx_oe_r <= 1'b0; tx_dp_r <= 1'b0; tx_dm_r <= 1'b0;
      end
    end
  end

  assign lnk.phy_interface_clock_output = clk_q_r;
  assign lnk.line_state = ls_r;
  assign tx_dp_out    = tx_dp_r;
  assign tx_dm_out    = tx_dm_r;
  assign tx_oe        = tx_oe_r;
  assign pullup_dp_en = pu_r;
  assign hs_term_en   = ht_r;
  assign por_busy     = busy_r;
  assign sop_sent     = sop_r;
endmodule
`default_nettype wire

// >>> design/ulr_link.sv
// Link-controller end: mode control, SE0 timing and HS reset detection
`default_nettype none
module ulr_link
  import ulr_pkg::*;
#(
  parameter int unsigned HS_IDLE_CYCLES = HS_IDLE_CYC,
  parameter int unsigned SAMPLE_CYCLES  = SAMPLE_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  ulr_if.link             phy,
  input  wire logic       start_hs,
  input  wire logic [1:0] test_sel,
  input  wire logic       test_en,
  input  wire logic       tx_req,
  input  wire logic       tx_bit,
  input  wire logic       tx_err,
  input  wire logic       link_reset,
  output logic            bus_reset,
  output logic            suspend_req,
  output logic            hs_active
);
  ulr_lstate_t st_r;
  logic [TMR_W-1:0] tmr_r;
  logic [1:0] opm_r;
  logic xs_r, ts_r, txv_r, txd_r, rst_r, br_r, sp_r, hs_r;
  wire logic se0 = (phy.line_state == LS_SE0);

  // RULE_24 cycle timers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ULR_FS_RUN; tmr_r <= '0; opm_r <= OPM_NORMAL;
      xs_r <= XCVR_FS; ts_r <= TERM_FS; txv_r <= 1'b0; txd_r <= 1'b0;
      rst_r <= 1'b1; br_r <= 1'b0; sp_r <= 1'b0; hs_r <= 1'b0;
    end else begin
      rst_r <= link_reset;
      br_r  <= 1'b0;
      sp_r  <= 1'b0;
      txv_r <= tx_req;
      txd_r <= tx_bit;
      // RULE_12 flag error by raw mode mid-packet
      if (tx_err && txv_r) opm_r <= OPM_RAW;
      case (st_r)
        ULR_FS_RUN: begin
          hs_r <= 1'b0;
          // RULE_16 long SE0 is reset
          tmr_r <= se0 ? tmr_r + 1'b1 : '0;
          if (se0 && tmr_r == TMR_W'(FS_RST_CYC)) begin br_r <= 1'b1; tmr_r <= '0; end
          // RULE_13 RULE_14 changes only while idle
          if (!tx_req && !txv_r && test_en) begin
            // RULE_15 HS selects for tests
            xs_r <= XCVR_HS; ts_r <= TERM_HS;
            opm_r <= test_sel[0] ? OPM_RAW : OPM_NORMAL;
            st_r <= ULR_TEST;
          end else if (!tx_req && !txv_r && start_hs) begin
            xs_r <= XCVR_HS; ts_r <= TERM_HS; opm_r <= OPM_NORMAL;
            tmr_r <= '0; st_r <= ULR_HS_RUN;
          end
        end
        ULR_HS_RUN: begin
          hs_r <= 1'b1;
          // RULE_17 RULE_18 RULE_19 idle timer then revert
          tmr_r <= se0 ? tmr_r + 1'b1 : '0;
          if (se0 && tmr_r == TMR_W'(HS_IDLE_CYCLES - 1)) begin
            xs_r <= XCVR_FS; ts_r <= TERM_FS; tmr_r <= '0; st_r <= ULR_REVERT_WAIT;
          end
        end
        ULR_REVERT_WAIT: begin
          hs_r  <= 1'b0;
          tmr_r <= tmr_r + 1'b1;
          // RULE_22 sample inside window
          if (tmr_r == TMR_W'(SAMPLE_CYCLES - 1)) begin
            tmr_r <= '0;
            // RULE_21 SE0 means reset; RULE_23 J means suspend
            if (se0) begin br_r <= 1'b1; st_r <= ULR_HANDSHAKE; end
            else begin sp_r <= 1'b1; st_r <= ULR_SUSPEND; end
          end
        end
        ULR_HANDSHAKE: st_r <= ULR_FS_RUN;
        ULR_SUSPEND: if (!se0 && phy.line_state != LS_J) st_r <= ULR_FS_RUN;
        ULR_TEST: if (!test_en) begin
          xs_r <= XCVR_FS; ts_r <= TERM_FS; opm_r <= OPM_NORMAL; st_r <= ULR_FS_RUN;
        end
        default: st_r <= ULR_FS_RUN;
      endcase
    end
  end

  assign phy.op_mode  = opm_r;
  assign phy.xcvr_sel = xs_r;
  assign phy.term_sel = ts_r;
  assign phy.tx_valid = txv_r;
  assign phy.tx_data  = txd_r;
  assign phy.if_reset = rst_r;
  assign bus_reset    = br_r;
  assign suspend_req  = sp_r;
  assign hs_active    = hs_r;
endmodule
`default_nettype wire

// >>> test/ulr_properties.sv
// Interface assertions between the PHY end and the link end
`default_nettype none
module ulr_properties
  import ulr_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES    = 50,
  parameter int unsigned HS_IDLE_CYCLES = 50
) (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       phy_interface_clock_output,
  input wire logic [1:0] line_state,
  input wire logic [1:0] op_mode,
  input wire logic       xcvr_sel,
  input wire logic       term_sel,
  input wire logic       tx_valid,
  input wire logic       if_reset,
  input wire logic       pll_locked,
  input wire logic       squelch,
  input wire logic       hs_diff_rx,
  input wire logic       bus_dp,
  input wire logic       bus_dm,
  input wire logic       por_busy
);
  logic        live_r;
  logic [7:0]  lk_r;
  logic [19:0] idle_r;
  // Decode is only judged when the previous cycle was out of reset too
  wire         ok = live_r && !por_busy;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      live_r <= 1'b0;
      lk_r   <= 8'h00;
      idle_r <= 20'h00000;
    end else begin
      live_r <= !por_busy && !if_reset;
      lk_r   <= !(pll_locked && !por_busy && !if_reset) ? 8'h00 : lk_r + {7'h00, lk_r != 8'hFF};
      idle_r <= (xcvr_sel == XCVR_HS && line_state == LS_SE0) ? idle_r + 20'h00001 : 20'h00000;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  clk_hold_a: assert property (
    !pll_locked && !$past(pll_locked) |-> !phy_interface_clock_output)
    else $error("interface clock ran before lock");
  clk_run_a: assert property (
    lk_r > LOCK_CYCLES + 4 |-> phy_interface_clock_output != $past(phy_interface_clock_output))
    else $error("interface clock not toggling");
  fs_code_a: assert property (
    ok && $past(xcvr_sel) == XCVR_FS |-> line_state == {$past(bus_dm), $past(bus_dp)})
    else $error("full speed line state wrong");
  hs_squelch_a: assert property (
    ok && $past(xcvr_sel) == XCVR_HS && $past(squelch) |-> line_state == LS_SE0)
    else $error("squelched line state not 00");
  hs_active_a: assert property (
    ok && $past({xcvr_sel, term_sel, squelch}) == 3'b000 |-> line_state == LS_J)
    else $error("high speed activity not J");
  chirp_rx_a: assert property (
    ok && $past({xcvr_sel, term_sel, squelch}) == 3'b010 |->
      line_state == ($past(hs_diff_rx) ? LS_J : LS_K))
    else $error("chirp line state wrong");
  no_rsvd_a: assert property (op_mode != OPM_RSVD)
    else $error("reserved op mode driven");
  mode_quiet_a: assert property (
    $changed(op_mode) |-> !tx_valid || op_mode == OPM_RAW)
    else $error("op mode changed during transmit");
  revert_time_a: assert property (
    $rose(xcvr_sel) && $past(term_sel) == TERM_HS && !$past(if_reset) |->
      $past(idle_r) >= HS_IDLE_CYCLES - 3 && $past(idle_r) <= HS_IDLE_CYCLES + 2)
    else $error("reversion at wrong idle count");
endmodule
`default_nettype wire

// >>> test/utmi_linestate_opmode_reset_tb_top.sv
// Bench driving both ends over the interface
`default_nettype none
module utmi_linestate_opmode_reset_tb_top import ulr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HS_IDLE_C = 50;
  localparam int SAMPLE_C  = 20;
  `define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
  logic core_clk = 1'b0;
  logic reset_n = 1'b0, pll_locked = 1'b0, bus_dp = 1'b1, bus_dm = 1'b0, hs_diff_rx = 1'b0;
  logic squelch = 1'b1, start_hs = 1'b0, test_en = 1'b0, tx_req = 1'b0, tx_bit = 1'b0, c0;
  logic tx_err = 1'b0, link_reset = 1'b0;
  logic [1:0] test_sel = 2'h0;
  logic tx_dp_out, tx_dm_out, tx_oe, pullup_dp_en, hs_term_en, por_busy, sop_sent;
  logic bus_reset, suspend_req, hs_active;
  int bad_count = 0, compares = 0, i, n, t_rev, t_ev, nr, ns, pu;
  typedef struct packed {logic dp; logic dm; logic [1:0] ls;} ulr_row_t;
  ulr_row_t rows [4] = '{'{1'b0, 1'b0, LS_SE0}, '{1'b1, 1'b0, LS_J}, '{1'b0, 1'b1, LS_K},
                         '{1'b1, 1'b1, LS_SE1}};
  ulr_if u_if ();
  always #10 core_clk = ~core_clk;
  ulr_phy #(.LOCK_CYCLES(5)) ulr_phy_inst (.core_clk, .reset_n, .lnk(u_if), .pll_locked,
    .bus_dp, .bus_dm, .hs_diff_rx, .squelch, .tx_dp_out, .tx_dm_out, .tx_oe, .pullup_dp_en,
    .hs_term_en, .por_busy, .sop_sent);
  ulr_link #(.HS_IDLE_CYCLES(HS_IDLE_C), .SAMPLE_CYCLES(SAMPLE_C)) ulr_link_inst (.core_clk,
    .reset_n, .phy(u_if), .start_hs, .test_sel, .test_en, .tx_req, .tx_bit, .tx_err,
    .link_reset, .bus_reset, .suspend_req, .hs_active);
  ulr_properties #(.LOCK_CYCLES(5), .HS_IDLE_CYCLES(HS_IDLE_C)) ulr_properties_inst (.core_clk,
    .reset_n, .phy_interface_clock_output(u_if.phy_interface_clock_output), .pll_locked,
    .line_state(u_if.line_state), .op_mode(u_if.op_mode), .xcvr_sel(u_if.xcvr_sel),
    .term_sel(u_if.term_sel), .tx_valid(u_if.tx_valid), .if_reset(u_if.if_reset), .squelch,
    .hs_diff_rx, .bus_dp, .bus_dm, .por_busy);
  task automatic tick(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic wait_por();
    n = 0;
    do begin tick(1); n++; end while (por_busy !== 1'b0 && n < 40);
    `CHK("por_busy", 1'b0, por_busy)
  endtask
  task automatic restart();
    reset_n = 1'b0;
    tick(6);
    reset_n = 1'b1;
    wait_por();
  endtask
  // Counts cycles of driven SE0 seen after the transmit request drops
  task automatic se0_drive(output int c);
    c = 0;
    repeat (8) begin
      tick(1);
      c += int'(tx_oe === 1'b1 && tx_dp_out === 1'b0 && tx_dm_out === 1'b0);
    end
  endtask
  task automatic revert(input logic dp, input logic dm, input logic rst);
    start_hs = 1'b1;
    squelch = 1'b0;
    n = 0;
    do begin tick(1); n++; end while (u_if.xcvr_sel !== XCVR_HS && n < 20);
    // A request left standing would send the link back to HS after the handshake
    start_hs = 1'b0;
    tick(2);
    `CHK("ls_active", LS_J, u_if.line_state)
    `CHK("hs_active", 1'b1, hs_active)
    `CHK("hs_term", 1'b1, hs_term_en)
    squelch = 1'b1;
    bus_dp = dp;
    bus_dm = dm;
    tick(2);
    `CHK("ls_squelch", LS_SE0, u_if.line_state)
    t_rev = -1; t_ev = -1; nr = 0; ns = 0;
    for (i = 0; i < 150; i++) begin
      tick(1);
      if (u_if.xcvr_sel === XCVR_FS && t_rev < 0) t_rev = i;
      if (i == t_rev + 2) pu = int'(pullup_dp_en === 1'b1);
      if (bus_reset === 1'b1) begin nr++; t_ev = i; end
      if (suspend_req === 1'b1) begin ns++; t_ev = i; end
    end
    `CHK("revert_time", 1'b1, t_rev >= HS_IDLE_C - 4 && t_rev <= HS_IDLE_C + 2)
    `CHK("pullup", 1, pu)
    `CHK("sample_gap", 1'b1, t_ev - t_rev >= SAMPLE_C - 1 && t_ev - t_rev <= SAMPLE_C + 2)
    `CHK("bus_reset", rst ? 1 : 0, nr)
    `CHK("suspend", rst ? 0 : 1, ns)
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    restart();
    tick(3);
    `CHK("clk_idle", 1'b0, u_if.phy_interface_clock_output)
    pll_locked = 1'b1;
    tick(12);
    c0 = u_if.phy_interface_clock_output;
    tick(1);
    `CHK("clk_toggle", 1'b1, c0 ^ u_if.phy_interface_clock_output)
    foreach (rows[k]) begin
      bus_dp = rows[k].dp;
      bus_dm = rows[k].dm;
      tick(2);
      `CHK("ls_fs", rows[k].ls, u_if.line_state)
    end
    bus_dp = 1'b1;
    bus_dm = 1'b0;
    tx_req = 1'b1;
    tx_bit = 1'b1;
    tick(3);
    `CHK("sop", 1'b1, sop_sent)
    tx_err = 1'b1;
    tick(2);
    `CHK("err_mode", OPM_RAW, u_if.op_mode)
    tx_req = 1'b0;
    tx_err = 1'b0;
    se0_drive(n);
    `CHK("eop_len", 2, n)
    link_reset = 1'b1;
    tick(3);
    `CHK("ext_reset", 1'b1, por_busy)
    link_reset = 1'b0;
    wait_por();
    revert(1'b1, 1'b0, 1'b0);
    start_hs = 1'b0;
    restart();
    revert(1'b0, 1'b0, 1'b1);
    start_hs = 1'b0;
    bus_dp = 1'b1;
    restart();
    test_sel = 2'h1;
    test_en = 1'b1;
    n = 0;
    do begin tick(1); n++; end while (u_if.op_mode !== OPM_RAW && n < 20);
    `CHK("test_sel", {XCVR_HS, TERM_HS}, {u_if.xcvr_sel, u_if.term_sel})
    tx_req = 1'b1;
    tick(4);
    `CHK("raw_j", 2'h2, {tx_dp_out, tx_dm_out})
    tx_req = 1'b0;
    se0_drive(n);
    `CHK("raw_eop", 0, n)
    report_and_stop();
  end
  // The whole run takes under a thousand cycles; three thousand means a hang
  initial begin
    #(3000 * 20);
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
